// ### common/rtm_map.svh
/*
 * Constants of the reloadable timer: widths, counts, reset values.
 * Assumes inclusion by bare name from the package and the timer files.
 */
`ifndef RTM_MAP_SVH
`define RTM_MAP_SVH

// Counter geometry
`define RTM_CNT_W 16
`define RTM_NUM_TIMERS 4
`define RTM_MAX_TIMERS 4

// Prescaler: divide by 2**exp, exp 0..7 gives 1..128
`define RTM_PSC_EXP_W 3
`define RTM_PSC_CNT_W 7

// Count values
`define RTM_RESTART_CNT 16'h0001
`define RTM_CNT_ONE 16'h0001
`define RTM_CNT_RST 16'h0000

// Reset levels
`define RTM_BIT_RST 1'b0
`define RTM_PSC_RST 7'h00

`endif

// ### common/rtm_pkg.sv
/*
 * Types shared by the reloadable timer design.
 * Assumes rtm_map.svh is on the include path.
 */
`default_nettype none

package rtm_pkg;
`include "rtm_map.svh"

   // Counting source and end-of-period behaviour
   typedef enum logic [1:0] {
      RTM_MODE_ONESHOT,
      RTM_MODE_CONT,
      RTM_MODE_COUNT
   } rtm_mode_t;

   // Static setup, held by software while the timer runs
   typedef struct packed {
      rtm_mode_t mode;
      logic [`RTM_PSC_EXP_W-1:0] psc_exp;
      logic output_polarity_select;
      logic out_en;
      logic [`RTM_CNT_W-1:0] reload;
   } rtm_cfg_t;

   // One-cycle software commands
   typedef struct packed {
      logic en_set;
      logic en_clr;
      logic cnt_load;
      logic [`RTM_CNT_W-1:0] cnt_value;
   } rtm_cmd_t;

   // Readable state
   typedef struct packed {
      logic [`RTM_CNT_W-1:0] count;
      logic enabled;
   } rtm_sts_t;

endpackage

`default_nettype wire

// ### rtl/rtm_edge_detect.sv
/*
 * Synchroniser and selectable edge detector for the timer input pin.
 * Assumes the pin toggles at no more than a quarter of the clock rate.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rtm_map.svh"

module rtm_edge_detect (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Pin and edge choice
   input wire logic i_pin,
   input wire logic i_rise_sel,
   // Edge pulse
   output logic o_edge
);
   import rtm_pkg::*;

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // First stage feeds only the second stage
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_reg <= `RTM_BIT_RST;
         sync_reg <= `RTM_BIT_RST;
         prev_reg <= `RTM_BIT_RST;
      end else begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Present against previous sample
   assign o_edge = i_rise_sel ? (sync_reg && !prev_reg) : (!sync_reg && prev_reg);

endmodule // rtm_edge_detect

`default_nettype wire

// ### rtl/rtm_prescaler.sv
/*
 * Power-of-two prescaler: one tick every 2**exp clocks while running.
 * Assumes exp is held stable while the timer runs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rtm_map.svh"

module rtm_prescaler #(
   parameter int PSC_W = `RTM_PSC_CNT_W
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Control
   input wire logic i_run,
   input wire logic [`RTM_PSC_EXP_W-1:0] i_exp,
   // Tick
   output logic o_tick
);
   import rtm_pkg::*;

   initial begin
      if (PSC_W != `RTM_PSC_CNT_W) $error("prescaler width must match exponent range");
   end

   logic [PSC_W-1:0] div_reg;
   logic [PSC_W-1:0] div_next;
   logic [PSC_W-1:0] mask;

   // Low exp bits all ones marks the end of each division period
   assign mask = PSC_W'((1 << i_exp) - 1);
   assign div_next = i_run ? PSC_W'(div_reg + 1'b1) : `RTM_PSC_RST;
   assign o_tick = i_run && ((div_reg & mask) == mask);

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_reg <= `RTM_PSC_RST;
      end else begin
         div_reg <= div_next;
      end
   end

endmodule // rtm_prescaler

`default_nettype wire

// ### rtl/rtm_timer_top.sv
/*
 * Bank of reloadable 16-bit up-counting timers with prescaler,
 * single-shot, continuous and external-edge counting modes.
 * Assumes software drives the setup ports as plain levels and the
 * command ports as one-cycle pulses, all synchronous to i_core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rtm_map.svh"

module rtm_timer_top #(
   parameter int NUM_TIMERS = `RTM_NUM_TIMERS,
   parameter int CNT_W = `RTM_CNT_W
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Software setup and commands, one entry per timer
   input wire rtm_pkg::rtm_cfg_t [NUM_TIMERS-1:0] i_cfg,
   input wire rtm_pkg::rtm_cmd_t [NUM_TIMERS-1:0] i_cmd,
   // Software-visible state
   output rtm_pkg::rtm_sts_t [NUM_TIMERS-1:0] o_sts,
   output logic [NUM_TIMERS-1:0] o_irq,
   // Timer pins
   input wire logic [NUM_TIMERS-1:0] i_tin,
   output logic [NUM_TIMERS-1:0] o_tout,
   output logic [NUM_TIMERS-1:0] o_tout_oe
);
   import rtm_pkg::*;

   // The counter logic is written for exactly the documented width
   initial begin
      if (NUM_TIMERS < 1 || NUM_TIMERS > `RTM_MAX_TIMERS) begin
         $error("timer count out of range");
      end
      if (CNT_W != `RTM_CNT_W) begin
         $error("counter width must be 16");
      end
   end

   // Clock-driven modes share the prescaler as their source
   function automatic logic uses_clock(input rtm_mode_t mode);
      uses_clock = (mode == RTM_MODE_ONESHOT) || (mode == RTM_MODE_CONT);
   endfunction

   // Modes that keep running after a reload
   function automatic logic is_repeating(input rtm_mode_t mode);
      is_repeating = (mode == RTM_MODE_CONT) || (mode == RTM_MODE_COUNT);
   endfunction

   genvar g;
   generate
      for (g = 0; g < NUM_TIMERS; g++) begin : g_timer

         // Setup fields
         rtm_mode_t mode;
         logic pol;
         logic [CNT_W-1:0] reload;

         // Advance sources
         logic psc_tick;
         logic pin_edge;
         logic psc_run;
         logic advance;

         // Count path
         logic [CNT_W-1:0] cnt_reg;
         logic [CNT_W-1:0] cnt_next;
         logic [CNT_W-1:0] cnt_inc;
         logic [CNT_W-1:0] terminal;
         logic hit;

         // Enable, interrupt, output
         logic en_reg;
         logic en_next;
         logic irq_reg;
         logic irq_next;
         logic tout_reg;
         logic tout_next;
         logic level_hold;
         logic level_toggled;
         logic level_shot;

         assign mode = i_cfg[g].mode;
         assign pol = i_cfg[g].output_polarity_select;
         assign reload = i_cfg[g].reload;

         // Prescaler halts while disabled so each start begins a whole period
         assign psc_run = en_reg && uses_clock(mode);

         rtm_prescaler #(
            .PSC_W(`RTM_PSC_CNT_W)
         ) u_psc (
            .i_core_clk(i_core_clk),
            .i_rst_b(i_rst_b),
            .i_run(psc_run),
            .i_exp(i_cfg[g].psc_exp),
            .o_tick(psc_tick)
         );

         // Edge choice shares the polarity bit
         rtm_edge_detect u_edge (
            .i_core_clk(i_core_clk),
            .i_rst_b(i_rst_b),
            .i_pin(i_tin[g]),
            .i_rise_sel(pol),
            .o_edge(pin_edge)
         );

         // Pin edges count only in counting mode, unscaled
         assign advance = en_reg && (uses_clock(mode) ? psc_tick :
                          ((mode == RTM_MODE_COUNT) && pin_edge));

         // Natural 16-bit wrap from FFFFH to 0000H
         assign cnt_inc = CNT_W'(cnt_reg + `RTM_CNT_ONE);

         // One past the reload value; 0000H reload gives 0001H, a full lap
         assign terminal = CNT_W'(reload + `RTM_CNT_ONE);

         // Compared after the increment
         assign hit = advance && (cnt_inc == terminal);

         // Software load wins over counting; a reload always restarts at 0001H
         always_comb begin
            cnt_next = cnt_reg;
            if (i_cmd[g].cnt_load) begin
               cnt_next = i_cmd[g].cnt_value;
            end else if (hit) begin
               cnt_next = `RTM_RESTART_CNT;
            end else if (advance) begin
               cnt_next = cnt_inc;
            end
         end

         // Set beats the single-shot self clear in the same cycle
         always_comb begin
            en_next = en_reg;
            if (i_cmd[g].en_set) begin
               en_next = 1'b1;
            end else if (i_cmd[g].en_clr) begin
               en_next = 1'b0;
            end else if (hit && !is_repeating(mode)) begin
               en_next = 1'b0;
            end
         end

         // One pulse per reload
         assign irq_next = hit;

         // Output level candidates
         assign level_hold = pol;
         assign level_toggled = hit ? !tout_reg : tout_reg;
         assign level_shot = hit ? !pol : pol;

         // Disabled timers park the pin at the programmed start level
         always_comb begin
            tout_next = tout_reg;
            case (mode)
               RTM_MODE_ONESHOT: begin
                  tout_next = level_shot;
               end
               RTM_MODE_CONT: begin
                  tout_next = en_reg ? level_toggled : level_hold;
               end
               RTM_MODE_COUNT: begin
                  tout_next = en_reg ? level_toggled : level_hold;
               end
               default: begin
                  tout_next = level_hold;
               end
            endcase
         end

         always_ff @(posedge i_core_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               cnt_reg <= `RTM_CNT_RST;
               en_reg <= `RTM_BIT_RST;
               irq_reg <= `RTM_BIT_RST;
               tout_reg <= `RTM_BIT_RST;
            end else begin
               cnt_reg <= cnt_next;
               en_reg <= en_next;
               irq_reg <= irq_next;
               tout_reg <= tout_next;
            end
         end

         // Single-shot level simply follows polarity, so a later flip lasts
         assign o_tout[g] = tout_reg;
         assign o_tout_oe[g] = i_cfg[g].out_en;
         assign o_irq[g] = irq_reg;
         assign o_sts[g].count = cnt_reg;
         assign o_sts[g].enabled = en_reg;

      end
   endgenerate

endmodule // rtm_timer_top

`default_nettype wire

// ### tb/reloadable_timer_16bit_test.sv
/* Self-checking bench for the timer bank, driving timer 0.
   Assumes the pin model and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module reloadable_timer_16bit_test;
   import rtm_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst_b = 1'b0;
   rtm_cfg_t [3:0] cfg = '0;
   rtm_cmd_t [3:0] cmd = '0;
   rtm_sts_t [3:0] sts;
   logic [3:0] irq;
   logic [3:0] tout;
   logic [3:0] oe;
   logic pin;
   logic busy;
   logic go = 1'b0;
   logic [7:0] npulse = 8'h00;
   int error_cnt = 0;
   int tests_run = 0;
   rtm_timer_top dut_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cfg(cfg), .i_cmd(cmd),
      .o_sts(sts), .o_irq(irq), .i_tin({3'b000, pin}), .o_tout(tout), .o_tout_oe(oe));
   rtm_pin_model pin_u (.i_core_clk(i_core_clk), .i_go(go), .i_pulses(npulse), .o_pin(pin),
      .o_busy(busy));
   initial begin
      forever #4 i_core_clk = ~i_core_clk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic cmd_pulse(input logic s, input logic c, input logic l, input logic [15:0] v);
      @(negedge i_core_clk);
      cmd[0] = '{s, c, l, v};
      @(negedge i_core_clk);
      cmd[0] = '0;
   endtask
   task automatic setup(input rtm_mode_t m, input logic [2:0] e, input logic p, input logic o,
      input logic [15:0] s, input logic [15:0] r);
      cmd_pulse(1'b0, 1'b1, 1'b0, 16'h0000);
      cfg[0] = '{m, e, p, o, r};
      cmd_pulse(1'b0, 1'b0, 1'b1, s);
      cmd_pulse(1'b1, 1'b0, 1'b0, 16'h0000);
   endtask
   task automatic wait_irq(input int n, input string nm);
      int m;
      m = 1;
      while (irq[0] !== 1'b1 && m < n + 4) begin
         @(negedge i_core_clk);
         m++;
      end
      chk(nm, n, m);
      if (irq[0] !== 1'b1) give_verdict();
   endtask
   task automatic burst(input logic [7:0] k);
      int t;
      t = 0;
      npulse = k;
      go = 1'b1;
      @(negedge i_core_clk);
      while (busy === 1'b1 && t < 1000) begin
         @(negedge i_core_clk);
         t++;
      end
      chk("pin busy", 1'b0, busy);
      if (busy !== 1'b0) give_verdict();
      go = 1'b0;
      // Two-flop sync plus edge detect before the count shows
      repeat (4) @(negedge i_core_clk);
   endtask
   task automatic t_shot;
      setup(RTM_MODE_ONESHOT, 3'h0, 1'b0, 1'b1, 16'h0001, 16'h0001);
      wait_irq(2, "shortest lap");
      chk("count", 16'h0001, sts[0].count);
      chk("enabled", 1'b0, sts[0].enabled);
      chk("tout", 1'b1, tout[0]);
      chk("oe", 1'b1, oe[0]);
      @(negedge i_core_clk);
      chk("tout", 1'b0, tout[0]);
      chk("count", 16'h0001, sts[0].count);
      $display("single-shot test done");
   endtask
   task automatic t_psc;
      setup(RTM_MODE_ONESHOT, 3'h7, 1'b0, 1'b1, 16'h0001, 16'h0002);
      cfg[0].output_polarity_select = 1'b1;
      npulse = 8'h10;
      go = 1'b1;
      wait_irq(257, "divide 128 lap");
      go = 1'b0;
      chk("tout", 1'b0, tout[0]);
      @(negedge i_core_clk);
      chk("tout", 1'b1, tout[0]);
      $display("prescale test done");
   endtask
   task automatic t_cont;
      setup(RTM_MODE_CONT, 3'h0, 1'b1, 1'b1, 16'hFFFE, 16'h0000);
      wait_irq(4, "wrap lap");
      chk("tout", 1'b0, tout[0]);
      @(negedge i_core_clk);
      wait_irq(65536, "full lap");
      chk("tout", 1'b1, tout[0]);
      chk("count", 16'h0001, sts[0].count);
      cmd_pulse(1'b0, 1'b1, 1'b0, 16'h0000);
      $display("continuous test done");
   endtask
   task automatic t_count(input logic p);
      setup(RTM_MODE_COUNT, 3'h7, p, 1'b0, 16'h0001, 16'h0005);
      chk("tout", p, tout[0]);
      chk("oe", 1'b0, oe[0]);
      burst(8'h03);
      chk("edges", 16'h0004, sts[0].count);
      burst(8'h02);
      chk("count", 16'h0001, sts[0].count);
      chk("tout", !p, tout[0]);
      $display("counting test done");
   endtask
   initial begin
      repeat (12) @(negedge i_core_clk);
      i_rst_b = 1'b1;
      @(negedge i_core_clk);
      chk("count", 16'h0000, sts[0].count);
      chk("irq", 1'b0, irq[0]);
      $display("reset test done");
      t_shot();
      t_psc();
      t_cont();
      t_count(1'b1);
      t_count(1'b0);
      give_verdict();
   end
endmodule // reloadable_timer_16bit_test
`default_nettype wire

// ### tb/rtm_pin_model.sv
/* Far-side driver of one timer input pin.
   Assumes the bench raises i_go to start a burst. */
`timescale 1ns/1ps
`default_nettype none
module rtm_pin_model (
   // Clock and request
   input wire logic i_core_clk,
   input wire logic i_go,
   input wire logic [7:0] i_pulses,
   // Pin side
   output logic o_pin,
   output logic o_busy
);
   logic go_q = 1'b0;
   logic ph = 1'b0;
   logic [8:0] left = 9'h000;
   initial o_pin = 1'b0;
   assign o_busy = left != 9'h000;
   // Each level held two clocks, so never above a quarter of the clock
   always @(posedge i_core_clk) begin
      go_q <= i_go;
      if (i_go && !go_q) begin
         left <= {i_pulses, 1'b0};
      end else if (o_busy) begin
         ph <= ~ph;
         if (ph) begin
            o_pin <= ~o_pin;
            left <= left - 9'h001;
         end
      end
   end
endmodule // rtm_pin_model
`default_nettype wire

// ### tb/rtm_timer_sva.sv
/* Assertions on timer 0 of the timer bank.
   Assumes the bench runs its scenarios on timer 0. */
`timescale 1ns/1ps
`default_nettype none
module rtm_timer_sva #(
   parameter int NUM_TIMERS = 4,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Setup and commands
   input wire rtm_pkg::rtm_cfg_t [NUM_TIMERS-1:0] i_cfg,
   input wire rtm_pkg::rtm_cmd_t [NUM_TIMERS-1:0] i_cmd,
   // Outputs and pins
   input wire rtm_pkg::rtm_sts_t [NUM_TIMERS-1:0] o_sts,
   input wire logic [NUM_TIMERS-1:0] o_irq,
   input wire logic [NUM_TIMERS-1:0] i_tin,
   input wire logic [NUM_TIMERS-1:0] o_tout,
   input wire logic [NUM_TIMERS-1:0] o_tout_oe
);
   import rtm_pkg::*;
   logic [15:0] cnt;
   logic shot;
   logic ld;
   logic pol;
   assign cnt = o_sts[0].count;
   assign shot = i_cfg[0].mode == RTM_MODE_ONESHOT;
   assign ld = i_cmd[0].cnt_load;
   assign pol = i_cfg[0].output_polarity_select;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   property p_irq_pulse; o_irq[0] |=> !o_irq[0]; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
   property p_restart; o_irq[0] && !$past(ld) |-> cnt == 16'h0001; endproperty
   a_restart: assert property (p_restart) else $error("no restart at 1");
   property p_stop; o_irq[0] && shot && !$past(i_cmd[0].en_set) |-> !o_sts[0].enabled;
   endproperty
   a_stop: assert property (p_stop) else $error("single-shot kept running");
   property p_blip; o_irq[0] && shot |-> o_tout[0] == !pol ##1 o_tout[0] == pol; endproperty
   a_blip: assert property (p_blip) else $error("bad single-shot output");
   property p_toggle; o_irq[0] && !shot |-> o_tout[0] != $past(o_tout[0]); endproperty
   a_toggle: assert property (p_toggle) else $error("output not toggled");
   property p_step; cnt != $past(cnt) && !$past(ld) && !o_irq[0] |-> cnt == $past(cnt) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("count step not one");
   property p_idle; !$past(o_sts[0].enabled) && !$past(ld) |-> $stable(cnt); endproperty
   a_idle: assert property (p_idle) else $error("count moved while off");
   property p_psc;
      i_cfg[0].mode != RTM_MODE_COUNT && i_cfg[0].psc_exp != 3'h0 && cnt != $past(cnt)
         && !$past(ld) && !ld |=> $stable(cnt);
   endproperty
   a_psc: assert property (p_psc) else $error("prescaler not applied");
   c_shot: cover property (o_irq[0] && shot);
   c_cont: cover property (o_irq[0] && i_cfg[0].mode == RTM_MODE_CONT);
   c_count: cover property (o_irq[0] && i_cfg[0].mode == RTM_MODE_COUNT);
endmodule // rtm_timer_sva
bind rtm_timer_top rtm_timer_sva #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W)) chk_u (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cfg(i_cfg), .i_cmd(i_cmd),
   .o_sts(o_sts), .o_irq(o_irq), .i_tin(i_tin), .o_tout(o_tout), .o_tout_oe(o_tout_oe));
`default_nettype wire
